/* File: hw/gdi_device.sv */
// Device-side instrument bus interface: command decode, handshakes, polls and register port.
`timescale 1ns/1ns

// Operation
// - IFC drops addressing and aborts transfers
// - Take-control while talker makes us controller
// - Match 5-bit address in command mode
// - Device clear clears regardless of addressing
// - Go-to-local while listener leaves remote
// - Group trigger while listener pulses trigger
// - Local lockout disables front panel
// - Selective clear acts only when addressed
// - Serial poll disable ends status byte
// - ATN true means command, false data
// - Release NRFD only when ready
// - DAV only while DIO stable; sample then
// - Release NDAC only after byte taken
// - EOI travels with final byte
// - Parallel poll drives assigned DIO line
// - Hold SRQ until serviced by poll
// - Unlisten, untalk drop addressed states
// - Universal commands act when unaddressed
// - Extended addressing needs secondary byte
// - Remote set only while REN true; REN false forces local
// - Ignore meaningless command codes silently
// - Bytes carried on eight DIO lines
// - Another talk address drops our talker
module gdi_device (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire gdi_pkg::gdi_reg_req_t reg_req,
    output logic [31:0] rdata,
    // Instrument bus
    input wire gdi_pkg::gdi_bus_in_t bus_in,
    output gdi_pkg::gdi_bus_oe_t bus_oe,
    output logic bus_out,
    // Device side
    output logic trigger,
    output logic dev_clear,
    output logic remote,
    output logic lockout,
    output logic ctrl_active
);

    gdi_pkg::gdi_state_t s;
    gdi_pkg::gdi_state_t next_s;

    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic dav;
    logic nrfd;
    logic ndac;
    logic [7:0] dio;

    // Every bus line is low-true, so invert once here.
    assign atn = ~bus_in.atn_b;
    assign ifc = ~bus_in.ifc_b;
    assign ren = ~bus_in.ren_b;
    assign eoi = ~bus_in.eoi_b;
    assign dav = ~bus_in.dav_b;
    assign nrfd = ~bus_in.nrfd_b;
    assign ndac = ~bus_in.ndac_b;
    assign dio = ~bus_in.dio_b;

    function automatic logic addr_match(input logic [4:0] code, input logic [4:0] mine);
        addr_match = (code == mine);
    endfunction

    always_comb begin
        logic involved;
        logic src_ok;
        logic ppoll;
        logic [6:0] b;
        gdi_pkg::gdi_stat_t st;
        involved = 1'b0;
        src_ok = 1'b0;
        ppoll = 1'b0;
        b = 7'h00;
        st = '0;
        next_s = s;
        next_s.trig = 1'b0;
        next_s.dclr = 1'b0;
        next_s.rdata = 32'h0000_0000;

        // Source handshake. The byte is latched before DAV so DIO cannot move under it.
        src_ok = s.talk && !atn && (s.spoll || s.tx_valid);
        unique case (s.sh)
            gdi_pkg::SH_IDLE: begin
                if (src_ok) begin
                    next_s.sh = gdi_pkg::SH_SETTLE;
                    next_s.cnt = gdi_pkg::SETTLE_LOAD;
                    next_s.sh_spoll = s.spoll;
                    next_s.sh_byte = s.spoll ? s.sp_byte : s.tx_byte;
                    next_s.sh_eoi = s.spoll ? 1'b0 : s.tx_eoi;
                end
            end
            gdi_pkg::SH_SETTLE: begin
                if (atn) begin
                    next_s.sh = gdi_pkg::SH_IDLE;
                end else if (s.cnt != gdi_pkg::CNT_ZERO) begin
                    next_s.cnt = s.cnt - gdi_pkg::CNT_ONE;
                end else if (!nrfd) begin
                    next_s.sh = gdi_pkg::SH_VALID;
                end
            end
            gdi_pkg::SH_VALID: begin
                if (atn) begin
                    next_s.sh = gdi_pkg::SH_IDLE;
                end else if (!ndac) begin
                    next_s.sh = gdi_pkg::SH_RELEASE;
                    if (s.sh_spoll) begin
                        // The controller has read our status byte, which services the request.
                        next_s.sp_byte[gdi_pkg::RQS_BIT] = 1'b0;
                    end else begin
                        next_s.tx_valid = 1'b0;
                    end
                end
            end
            gdi_pkg::SH_RELEASE: begin
                next_s.sh = gdi_pkg::SH_IDLE;
            end
        endcase

        // Register writes come after the source so a software write of RQS wins.
        if (reg_req.wr) begin
            case (reg_req.addr)
                gdi_pkg::OFS_CTRL: begin
                    next_s.ctrl = gdi_pkg::gdi_ctrl_t'(reg_req.wdata);
                    next_s.ctrl.rsvd = '0;
                end
                gdi_pkg::OFS_TX: begin
                    if (!s.tx_valid) begin
                        next_s.tx_byte = reg_req.wdata[7:0];
                        next_s.tx_eoi = reg_req.wdata[8];
                        next_s.tx_valid = 1'b1;
                    end
                end
                gdi_pkg::OFS_SPB: begin
                    next_s.sp_byte = reg_req.wdata[7:0];
                end
                default: begin
                end
            endcase
        end

        st.listen = s.listen;
        st.talk = s.talk;
        st.remote = s.remote;
        st.lockout = s.lockout;
        st.spoll = s.spoll;
        st.ctrl_active = s.ctrl_active;
        st.rx_valid = s.rx_valid;
        st.tx_busy = s.tx_valid;
        st.srq = s.sp_byte[gdi_pkg::RQS_BIT];
        if (reg_req.rd) begin
            case (reg_req.addr)
                gdi_pkg::OFS_CTRL: next_s.rdata = s.ctrl;
                gdi_pkg::OFS_STAT: next_s.rdata = st;
                gdi_pkg::OFS_TX: next_s.rdata = {23'h000000, s.tx_eoi, s.tx_byte};
                gdi_pkg::OFS_RX: begin
                    next_s.rdata = {23'h000000, s.rx_eoi, s.rx_byte};
                    next_s.rx_valid = 1'b0;
                end
                gdi_pkg::OFS_SPB: next_s.rdata = {24'h000000, s.sp_byte};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Acceptor handshake: always in command mode, in data mode only as a pure listener.
        involved = atn || (s.listen && !s.talk);
        b = dio[6:0];
        unique case (s.ah)
            gdi_pkg::AH_IDLE: begin
                if (involved && (atn || !s.rx_valid)) begin
                    next_s.ah = gdi_pkg::AH_READY;
                end
            end
            gdi_pkg::AH_READY: begin
                if (!involved) begin
                    next_s.ah = gdi_pkg::AH_IDLE;
                end else if (dav) begin
                    next_s.ah = gdi_pkg::AH_TAKEN;
                    if (atn) begin
                        unique case (b[6:5])
                            gdi_pkg::GRP_CMD: begin
                                next_s.lpend = 1'b0;
                                next_s.tpend = 1'b0;
                                case (b)
                                    gdi_pkg::CMD_GTL: begin
                                        if (s.listen && ren) begin
                                            next_s.remote = 1'b0;
                                        end
                                    end
                                    gdi_pkg::CMD_SDC: begin
                                        if (s.listen) begin
                                            next_s.dclr = 1'b1;
                                            next_s.tx_valid = 1'b0;
                                            next_s.rx_valid = 1'b0;
                                        end
                                    end
                                    gdi_pkg::CMD_GET: begin
                                        if (s.listen) begin
                                            next_s.trig = 1'b1;
                                        end
                                    end
                                    gdi_pkg::CMD_TCT: begin
                                        if (s.talk) begin
                                            next_s.ctrl_active = 1'b1;
                                        end
                                    end
                                    gdi_pkg::CMD_LLO: begin
                                        if (ren) begin
                                            next_s.lockout = 1'b1;
                                        end
                                    end
                                    gdi_pkg::CMD_DCL: begin
                                        next_s.dclr = 1'b1;
                                        next_s.tx_valid = 1'b0;
                                        next_s.rx_valid = 1'b0;
                                    end
                                    gdi_pkg::CMD_SPE: next_s.spoll = 1'b1;
                                    gdi_pkg::CMD_SPD: next_s.spoll = 1'b0;
                                    default: begin
                                        // Codes we have no function for are taken and dropped.
                                    end
                                endcase
                            end
                            gdi_pkg::GRP_LISTEN: begin
                                next_s.tpend = 1'b0;
                                next_s.lpend = 1'b0;
                                if (b == gdi_pkg::CMD_UNL) begin
                                    next_s.listen = 1'b0;
                                end else if (s.ctrl.listen_en &&
                                             addr_match(b[4:0], s.ctrl.my_addr)) begin
                                    if (s.ctrl.ext_en) begin
                                        next_s.lpend = 1'b1;
                                    end else begin
                                        next_s.listen = 1'b1;
                                        next_s.remote = s.remote | ren;
                                    end
                                end
                            end
                            gdi_pkg::GRP_TALK: begin
                                next_s.lpend = 1'b0;
                                next_s.tpend = 1'b0;
                                if (b == gdi_pkg::CMD_UNT) begin
                                    next_s.talk = 1'b0;
                                end else if (s.ctrl.talk_en &&
                                             addr_match(b[4:0], s.ctrl.my_addr)) begin
                                    if (s.ctrl.ext_en) begin
                                        next_s.tpend = 1'b1;
                                    end else begin
                                        next_s.talk = 1'b1;
                                    end
                                end else begin
                                    next_s.talk = 1'b0;
                                end
                            end
                            gdi_pkg::GRP_SEC: begin
                                if (s.lpend && addr_match(b[4:0], s.ctrl.sec_addr)) begin
                                    next_s.listen = 1'b1;
                                    next_s.remote = s.remote | ren;
                                end
                                if (s.tpend) begin
                                    next_s.talk = addr_match(b[4:0], s.ctrl.sec_addr);
                                end
                            end
                        endcase
                    end else begin
                        next_s.rx_byte = dio;
                        next_s.rx_eoi = eoi;
                        next_s.rx_valid = 1'b1;
                    end
                end
            end
            gdi_pkg::AH_TAKEN: begin
                if (!dav || !involved) begin
                    next_s.ah = gdi_pkg::AH_IDLE;
                end
            end
            default: begin
                next_s.ah = gdi_pkg::AH_IDLE;
            end
        endcase

        // Dropping REN returns the device to local and ends the lockout.
        if (!ren) begin
            next_s.remote = 1'b0;
            next_s.lockout = 1'b0;
        end

        if (ifc) begin
            next_s.listen = 1'b0;
            next_s.talk = 1'b0;
            next_s.lpend = 1'b0;
            next_s.tpend = 1'b0;
            next_s.spoll = 1'b0;
            next_s.ctrl_active = 1'b0;
            next_s.ah = gdi_pkg::AH_IDLE;
            next_s.sh = gdi_pkg::SH_IDLE;
        end

        // Pin drives for the next cycle, all pull-low.
        next_s.oe.nrfd = involved && !ifc && (next_s.ah != gdi_pkg::AH_READY);
        next_s.oe.ndac = involved && !ifc && (next_s.ah != gdi_pkg::AH_TAKEN);
        next_s.oe.dav = (next_s.sh == gdi_pkg::SH_VALID);
        next_s.oe.eoi = next_s.sh_eoi && ((next_s.sh == gdi_pkg::SH_SETTLE) ||
                                         (next_s.sh == gdi_pkg::SH_VALID));
        next_s.oe.srq = next_s.sp_byte[gdi_pkg::RQS_BIT];
        ppoll = atn && eoi && s.ctrl.pp_en && !ifc;
        if (next_s.sh != gdi_pkg::SH_IDLE) begin
            next_s.oe.dio = next_s.sh_byte;
        end else if (ppoll && (next_s.sp_byte[gdi_pkg::RQS_BIT] == s.ctrl.pp_sense)) begin
            next_s.oe.dio = 8'(8'h01 << s.ctrl.pp_line);
        end else begin
            next_s.oe.dio = 8'h00;
        end
        next_s.pin_low = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.ctrl <= gdi_pkg::CTRL_RST;
            s.ah <= gdi_pkg::AH_IDLE;
            s.sh <= gdi_pkg::SH_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign bus_oe = s.oe;
    assign bus_out = s.pin_low;
    assign trigger = s.trig;
    assign dev_clear = s.dclr;
    assign remote = s.remote;
    assign lockout = s.lockout;
    assign ctrl_active = s.ctrl_active;

endmodule // gdi_device

/* File: hw/gdi_pkg.sv */
// Constants, register layouts, carrier structs and state types of the instrument bus interface.
package gdi_pkg;

    // Timing: the source lets DIO settle before it asserts DAV.
    localparam int CLK_NS = 50;
    localparam int SETTLE_NS = 500;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Register byte addresses.
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_STAT = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_TX = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RX = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_SPB = 5'h10;

    // Bus command codes in the low seven bits of a command byte.
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_TCT = 7'h09;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3f;
    localparam logic [6:0] CMD_UNT = 7'h5f;

    // Command groups held in bits 6:5 of a command byte.
    localparam logic [1:0] GRP_CMD = 2'h0;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [1:0] GRP_SEC = 2'h3;

    // Request-service bit of the status byte.
    localparam int RQS_BIT = 6;

    typedef struct packed {
        logic [13:0] rsvd;
        logic pp_en;
        logic pp_sense;
        logic [2:0] pp_line;
        logic [4:0] sec_addr;
        logic ext_en;
        logic talk_en;
        logic listen_en;
        logic [4:0] my_addr;
    } gdi_ctrl_t;

    localparam gdi_ctrl_t CTRL_RST = 32'h0000_0000;

    typedef struct packed {
        logic [22:0] rsvd;
        logic srq;
        logic tx_busy;
        logic rx_valid;
        logic ctrl_active;
        logic spoll;
        logic lockout;
        logic remote;
        logic talk;
        logic listen;
    } gdi_stat_t;

    // Bus lines as seen on the wire; low means true.
    typedef struct packed {
        logic atn_b;
        logic ifc_b;
        logic ren_b;
        logic eoi_b;
        logic dav_b;
        logic nrfd_b;
        logic ndac_b;
        logic srq_b;
        logic [7:0] dio_b;
    } gdi_bus_in_t;

    // Pull-low enables; a set bit asserts that line true.
    typedef struct packed {
        logic eoi;
        logic dav;
        logic nrfd;
        logic ndac;
        logic srq;
        logic [7:0] dio;
    } gdi_bus_oe_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } gdi_reg_req_t;

    typedef enum logic [1:0] {
        AH_IDLE = 2'b00,
        AH_READY = 2'b01,
        AH_TAKEN = 2'b10
    } gdi_ah_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_SETTLE = 2'b01,
        SH_VALID = 2'b10,
        SH_RELEASE = 2'b11
    } gdi_sh_t;

    typedef struct packed {
        gdi_ctrl_t ctrl;
        gdi_ah_t ah;
        gdi_sh_t sh;
        logic [CNT_W-1:0] cnt;
        logic [7:0] rx_byte;
        logic rx_eoi;
        logic rx_valid;
        logic [7:0] tx_byte;
        logic tx_eoi;
        logic tx_valid;
        logic [7:0] sh_byte;
        logic sh_eoi;
        logic sh_spoll;
        logic [7:0] sp_byte;
        logic lpend;
        logic tpend;
        logic listen;
        logic talk;
        logic remote;
        logic lockout;
        logic spoll;
        logic ctrl_active;
        logic trig;
        logic dclr;
        gdi_bus_oe_t oe;
        logic pin_low;
        logic [31:0] rdata;
    } gdi_state_t;

endpackage

/* File: tb/gdi_ctl_model.sv */
// Behavioural bus controller and peer acceptor on the far side of the interface.
`timescale 1ns/1ns
module gdi_ctl_model (
    // Clock
    input wire logic clk,
    // Instrument bus
    input wire gdi_pkg::gdi_bus_oe_t bus_oe,
    output gdi_pkg::gdi_bus_in_t bus_in
);
    logic atn, ifc, ren, eoi, dav, nrfd, ndac;
    logic [7:0] dio;
    int n;
    // Released lines float high on the pull-ups, so a wire is low only while someone pulls.
    assign bus_in = {~atn, ~ifc, ~ren, ~(eoi | bus_oe.eoi), ~(dav | bus_oe.dav),
        ~(nrfd | bus_oe.nrfd), ~(ndac | bus_oe.ndac), ~bus_oe.srq, ~(dio | bus_oe.dio)};
    task automatic init();
        {atn, ifc, ren, eoi, dav, nrfd, ndac, dio} = 15'h0300;
    endtask
    task automatic lines(input logic [3:0] v);
        @(posedge clk);
        {atn, eoi, ifc, ren} <= v;
    endtask
    task automatic send(input logic a, input logic e, input logic [7:0] b);
        @(posedge clk);
        {atn, eoi, dio, nrfd, ndac} <= {a, e, b, 2'b00};
        n = 0;
        do begin @(posedge clk); n++; end while (bus_in.nrfd_b !== 1'b1 && n < 300);
        dav <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (bus_in.ndac_b !== 1'b1 && n < 300);
        {dav, dio, eoi, nrfd, ndac} <= {10'h000, 2'b11};
    endtask
    task automatic recv(output logic [8:0] v);
        @(posedge clk);
        nrfd <= 1'b0;
        n = 0;
        do begin @(posedge clk); n++; end while (bus_in.dav_b !== 1'b0 && n < 300);
        v = {~bus_in.eoi_b, ~bus_in.dio_b};
        {nrfd, ndac} <= 2'b10;
        n = 0;
        do begin @(posedge clk); n++; end while (bus_in.dav_b !== 1'b1 && n < 300);
        ndac <= 1'b1;
    endtask
endmodule // gdi_ctl_model

/* File: tb/gdi_device_interface_tb.sv */
// Self-checking bench for the instrument bus interface against a controller model.
`timescale 1ns/1ns
module gdi_device_interface_tb;
    logic clk;
    logic rst_b;
    gdi_pkg::gdi_reg_req_t reg_req;
    logic [31:0] rdata;
    gdi_pkg::gdi_bus_in_t bus_in;
    gdi_pkg::gdi_bus_oe_t bus_oe;
    logic bus_out, trigger, dev_clear, remote, lockout, ctrl_active;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_trig = 0;
    int n_clr = 0;
    logic [31:0] rv;
    logic [8:0] bv;
    gdi_device gdi_device_inst (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .rdata(rdata),
        .bus_in(bus_in), .bus_oe(bus_oe), .bus_out(bus_out), .trigger(trigger),
        .dev_clear(dev_clear), .remote(remote), .lockout(lockout), .ctrl_active(ctrl_active));
    gdi_ctl_model gdi_ctl_model_inst (.clk(clk), .bus_oe(bus_oe), .bus_in(bus_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (trigger === 1'b1) n_trig++;
        if (dev_clear === 1'b1) n_clr++;
        if (cycles == 6000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask
    task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
        rd(gdi_pkg::OFS_STAT, rv);
        check(rv & mask, exp);
    endtask
    task automatic cmd(input logic [6:0] c);
        gdi_ctl_model_inst.send(1'b1, 1'b0, {1'b0, c});
        repeat (3) @(posedge clk);
    endtask
    task automatic t_listen();
        wr(gdi_pkg::OFS_CTRL, 32'h65);
        rd(5'h14, rv);
        check(rv, 32'h0);
        cmd(7'h25);
        stat(32'h5, 32'h1);
        gdi_ctl_model_inst.lines(4'h1);
        cmd(7'h25);
        stat(32'h5, 32'h5);
        gdi_ctl_model_inst.send(1'b0, 1'b1, 8'ha5);
        rd(gdi_pkg::OFS_RX, rv);
        check(rv, 32'h1a5);
        $display("listen test done");
    endtask
    task automatic t_cmds();
        cmd(gdi_pkg::CMD_GET);
        check(n_trig, 1);
        cmd(gdi_pkg::CMD_LLO);
        check(lockout, 1);
        cmd(gdi_pkg::CMD_GTL);
        check(remote, 0);
        cmd(gdi_pkg::CMD_SDC);
        check(n_clr, 1);
        cmd(7'h02);
        stat(32'h3f, 32'h09);
        cmd(gdi_pkg::CMD_UNL);
        stat(32'h1, 32'h0);
        cmd(gdi_pkg::CMD_SDC);
        cmd(gdi_pkg::CMD_GET);
        check(n_clr + n_trig * 16, 32'h11);
        cmd(gdi_pkg::CMD_DCL);
        check(n_clr, 2);
        $display("command test done");
    endtask
    task automatic t_talk();
        cmd(7'h45);
        stat(32'h2, 32'h2);
        wr(gdi_pkg::OFS_TX, 32'h13c);
        gdi_ctl_model_inst.lines(4'h1);
        gdi_ctl_model_inst.recv(bv);
        check(bv, 9'h13c);
        stat(32'h80, 32'h0);
        cmd(gdi_pkg::CMD_TCT);
        check(ctrl_active, 1);
        cmd(7'h46);
        stat(32'h2, 32'h0);
        cmd(7'h25);
        gdi_ctl_model_inst.lines(4'h3);
        gdi_ctl_model_inst.lines(4'h1);
        stat(32'h23, 32'h0);
        $display("talk test done");
    endtask
    task automatic t_spoll();
        wr(gdi_pkg::OFS_SPB, 32'h41);
        repeat (2) @(posedge clk);
        check(bus_in.srq_b, 0);
        cmd(gdi_pkg::CMD_SPE);
        cmd(7'h45);
        gdi_ctl_model_inst.lines(4'h1);
        gdi_ctl_model_inst.recv(bv);
        check(bv[7:0], 8'h41);
        gdi_ctl_model_inst.recv(bv);
        check({bus_in.srq_b, bv[7:0]}, 9'h101);
        gdi_ctl_model_inst.lines(4'h9);
        cmd(gdi_pkg::CMD_SPD);
        stat(32'h10, 32'h0);
        cmd(gdi_pkg::CMD_UNT);
        stat(32'h2, 32'h0);
        $display("serial poll test done");
    endtask
    task automatic t_ppoll_ext();
        wr(gdi_pkg::OFS_CTRL, 32'h36065);
        wr(gdi_pkg::OFS_SPB, 32'h40);
        gdi_ctl_model_inst.lines(4'hd);
        repeat (3) @(posedge clk);
        check({bus_out, bus_oe.dio}, 9'h008);
        wr(gdi_pkg::OFS_SPB, 32'h0);
        repeat (3) @(posedge clk);
        check(bus_oe.dio, 8'h00);
        gdi_ctl_model_inst.lines(4'h9);
        wr(gdi_pkg::OFS_CTRL, 32'h2e5);
        cmd(7'h25);
        stat(32'h1, 32'h0);
        cmd(7'h62);
        stat(32'h1, 32'h1);
        $display("poll and extended address test done");
    endtask
    initial begin
        rst_b = 1'b0;
        reg_req = '0;
        gdi_ctl_model_inst.init();
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        t_listen();
        t_cmds();
        t_talk();
        t_spoll();
        t_ppoll_ext();
        give_verdict();
    end
endmodule // gdi_device_interface_tb

/* File: tb/gdi_device_monitor.sv */
// Concurrent checks on the ports of the instrument bus interface.
`timescale 1ns/1ns
module gdi_device_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire gdi_pkg::gdi_reg_req_t reg_req,
    input wire logic [31:0] rdata,
    // Instrument bus
    input wire gdi_pkg::gdi_bus_in_t bus_in,
    input wire gdi_pkg::gdi_bus_oe_t bus_oe,
    input wire logic bus_out,
    // Device side
    input wire logic trigger,
    input wire logic dev_clear,
    input wire logic remote,
    input wire logic lockout,
    input wire logic ctrl_active
);
    logic [6:0] cmd;
    logic cmd_ok;
    assign cmd = ~bus_in.dio_b[6:0];
    assign cmd_ok = !bus_in.atn_b && !bus_in.dav_b;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Command effects may land one or two edges after the byte is sampled.
    property p_ifc_clears;
        !bus_in.ifc_b |=> !ctrl_active && !bus_oe.nrfd && !bus_oe.ndac;
    endproperty
    a_ifc_clears: assert property (p_ifc_clears)
        else $error("interface clear left state behind");
    property p_take_ctl;
        $rose(ctrl_active) |-> $past(cmd_ok && cmd == gdi_pkg::CMD_TCT)
            || $past(cmd_ok && cmd == gdi_pkg::CMD_TCT, 2);
    endproperty
    a_take_ctl: assert property (p_take_ctl)
        else $error("control taken without take-control byte");
    property p_clear;
        dev_clear |-> $past(cmd_ok && (cmd == gdi_pkg::CMD_DCL || cmd == gdi_pkg::CMD_SDC))
            || $past(cmd_ok && (cmd == gdi_pkg::CMD_DCL || cmd == gdi_pkg::CMD_SDC), 2);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear pulse without clear byte");
    property p_trig;
        trigger |-> $past(cmd_ok && cmd == gdi_pkg::CMD_GET)
            || $past(cmd_ok && cmd == gdi_pkg::CMD_GET, 2);
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger pulse without trigger byte");
    property p_lock;
        $rose(lockout) |-> ($past(cmd_ok && cmd == gdi_pkg::CMD_LLO)
            || $past(cmd_ok && cmd == gdi_pkg::CMD_LLO, 2)) && $past(!bus_in.ren_b);
    endproperty
    a_lock: assert property (p_lock)
        else $error("lockout set without lockout byte");
    property p_dav_ready;
        $rose(bus_oe.dav) |-> $past(bus_in.nrfd_b);
    endproperty
    a_dav_ready: assert property (p_dav_ready)
        else $error("data valid raised while not ready");
    property p_dio_stable;
        bus_oe.dav |-> $stable(bus_oe.dio) && $stable(bus_oe.eoi);
    endproperty
    a_dio_stable: assert property (p_dio_stable)
        else $error("data lines moved while data valid");
    property p_ndac_taken;
        $fell(bus_oe.ndac) && $rose(bus_oe.nrfd) |-> $past(!bus_in.dav_b);
    endproperty
    a_ndac_taken: assert property (p_ndac_taken)
        else $error("byte accepted without data valid");
    c_trig: cover property ($rose(trigger));
    c_ctl: cover property ($rose(ctrl_active));
    c_dav: cover property ($rose(bus_oe.dav));
endmodule // gdi_device_monitor

bind gdi_device gdi_device_monitor gdi_device_monitor_inst (.clk(clk), .rst_b(rst_b),
    .reg_req(reg_req), .rdata(rdata), .bus_in(bus_in), .bus_oe(bus_oe), .bus_out(bus_out),
    .trigger(trigger), .dev_clear(dev_clear), .remote(remote), .lockout(lockout),
    .ctrl_active(ctrl_active));
